// ---- hw/gpf_global_pin_cfg.sv ----
// Global pin-function configuration: register file behind the indexed
// configuration port, three reset wells, ROM window decode and routing.
// Assumes reset and strap pins are asynchronous; port strobes are synchronous.
`timescale 1ns/1ps
`default_nettype none

module gpf_global_pin_cfg (
  // Clocking
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // Well resets and strap, pin level
  input wire logic resume_well_reset_n,
  input wire logic battery_reset_n,
  input wire logic strap_serial_flash_en,
  // Configuration port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Host memory cycle
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic rom_hit,
  // Pin routing
  output gpf_pkg::gpf_route_t route
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rsm_n_s;
  logic bat_n_s;
  logic strap_s;

  gpf_sync3 #(.INIT(1'b1)) u_sync_rsm (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .async_in(resume_well_reset_n),
    .sync_out(rsm_n_s)
  );

  gpf_sync3 #(.INIT(1'b1)) u_sync_bat (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .async_in(battery_reset_n),
    .sync_out(bat_n_s)
  );

  gpf_sync3 #(.INIT(1'b0)) u_sync_strap (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .async_in(strap_serial_flash_en),
    .sync_out(strap_s)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rom_page_hit(input logic [31:0] addr, input logic [15:0] page);
    rom_page_hit = (addr[31:16] == page);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  // ----------------------------------------------------------------
  // System-well registers
  // ----------------------------------------------------------------
  logic flash_en_r;
  logic flash_en_nxt;
  logic [2:0] strap_wait_r;
  logic [2:0] strap_wait_nxt;
  logic [7:0] rom_port_r;
  logic [7:0] rom_port_nxt;
  logic [7:0] alert_sel_r;
  logic [7:0] alert_sel_nxt;
  logic [7:0] test_a_r;
  logic [7:0] test_a_nxt;
  logic [7:0] test_b_r;
  logic [7:0] test_b_nxt;
  logic [7:0] port_wd;

  always_comb begin
    flash_en_nxt = flash_en_r;
    strap_wait_nxt = strap_wait_r;
    rom_port_nxt = rom_port_r;
    alert_sel_nxt = alert_sel_r;
    test_a_nxt = test_a_r;
    test_b_nxt = test_b_r;
    port_wd = cfg_wdata;
    // Reserved mode codes are refused; the old mode field stays
    if (cfg_wdata[gpf_pkg::PORT_MODE_TOP_BIT]) begin
      port_wd[2:0] = rom_port_r[2:0];
    end
    // The strap synchroniser is cleared by reset too, so follow it until it has refilled
    if (strap_wait_r != 3'h0) begin
      strap_wait_nxt = strap_wait_r - 3'h1;
      flash_en_nxt = strap_s;
    end else if (cfg_wr && cfg_index == gpf_pkg::GLOBAL_OPT_IDX) begin
      flash_en_nxt = cfg_wdata[gpf_pkg::FLASH_EN_BIT];
    end
    if (cfg_wr) begin
      unique case (cfg_index)
        gpf_pkg::ROM_PORT_IDX: begin
          rom_port_nxt = merge(rom_port_r, port_wd, gpf_pkg::ROM_PORT_MASK);
        end
        gpf_pkg::ALERT_PINSEL_IDX: begin
          alert_sel_nxt = merge(alert_sel_r, cfg_wdata, gpf_pkg::ALERT_PINSEL_MASK);
        end
        gpf_pkg::TEST_A_IDX: begin
          test_a_nxt = cfg_wdata;
        end
        gpf_pkg::TEST_B_IDX: begin
          test_b_nxt = cfg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flash_en_r <= 1'b0;
      strap_wait_r <= gpf_pkg::STRAP_WAIT_CYCLES;
      rom_port_r <= gpf_pkg::ROM_PORT_RST;
      alert_sel_r <= gpf_pkg::ALERT_PINSEL_RST;
      test_a_r <= gpf_pkg::TEST_RST;
      test_b_r <= gpf_pkg::TEST_RST;
    end else if (ce) begin
      flash_en_r <= flash_en_nxt;
      strap_wait_r <= strap_wait_nxt;
      rom_port_r <= rom_port_nxt;
      alert_sel_r <= alert_sel_nxt;
      test_a_r <= test_a_nxt;
      test_b_r <= test_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Standby-well registers (resume-well reset only)
  // ----------------------------------------------------------------
  logic [7:0] i2c_sys_r;
  logic [7:0] i2c_sys_nxt;
  logic [7:0] multi_sys_r;
  logic [7:0] multi_sys_nxt;
  logic [7:0] power_sel_r;
  logic [7:0] power_sel_nxt;

  always_comb begin
    i2c_sys_nxt = i2c_sys_r;
    multi_sys_nxt = multi_sys_r;
    power_sel_nxt = power_sel_r;
    if (cfg_wr) begin
      unique case (cfg_index)
        gpf_pkg::I2C_PINSEL_IDX: begin
          i2c_sys_nxt = cfg_wdata & gpf_pkg::I2C_SYS_MASK;
        end
        gpf_pkg::MULTIFUNC_IDX: begin
          multi_sys_nxt = cfg_wdata & gpf_pkg::MULTI_SYS_MASK;
        end
        gpf_pkg::POWER_PINSEL_IDX: begin
          power_sel_nxt = cfg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // System reset leaves these alone; they ride out host resets
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (!rsm_n_s) begin
        i2c_sys_r <= gpf_pkg::I2C_PINSEL_RST & gpf_pkg::I2C_SYS_MASK;
        multi_sys_r <= gpf_pkg::MULTIFUNC_RST & gpf_pkg::MULTI_SYS_MASK;
        power_sel_r <= gpf_pkg::POWER_PINSEL_RST;
      end else begin
        i2c_sys_r <= i2c_sys_nxt;
        multi_sys_r <= multi_sys_nxt;
        power_sel_r <= power_sel_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Battery-well bits (battery reset only)
  // ----------------------------------------------------------------
  logic [7:0] i2c_bat_r;
  logic [7:0] i2c_bat_nxt;
  logic [7:0] multi_bat_r;
  logic [7:0] multi_bat_nxt;

  always_comb begin
    i2c_bat_nxt = i2c_bat_r;
    multi_bat_nxt = multi_bat_r;
    if (cfg_wr && cfg_index == gpf_pkg::I2C_PINSEL_IDX) begin
      i2c_bat_nxt = cfg_wdata & gpf_pkg::I2C_BAT_MASK;
    end
    if (cfg_wr && cfg_index == gpf_pkg::MULTIFUNC_IDX) begin
      multi_bat_nxt = cfg_wdata & gpf_pkg::MULTI_BAT_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (!bat_n_s) begin
        i2c_bat_r <= gpf_pkg::I2C_PINSEL_RST & gpf_pkg::I2C_BAT_MASK;
        multi_bat_r <= gpf_pkg::MULTIFUNC_RST & gpf_pkg::MULTI_BAT_MASK;
      end else begin
        i2c_bat_r <= i2c_bat_nxt;
        multi_bat_r <= multi_bat_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read-back and ROM window decode
  // ----------------------------------------------------------------
  logic [7:0] i2c_sel;
  logic [7:0] multi_sel;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rom_hit_r;
  logic rom_hit_nxt;

  assign i2c_sel = i2c_sys_r | i2c_bat_r;
  assign multi_sel = multi_sys_r | multi_bat_r;

  always_comb begin
    rdata_nxt = rdata_r;
    if (cfg_rd) begin
      unique case (cfg_index)
        gpf_pkg::GLOBAL_OPT_IDX: rdata_nxt = {6'h00, flash_en_r, 1'b0};
        gpf_pkg::ROM_PORT_IDX: rdata_nxt = rom_port_r;
        gpf_pkg::ALERT_PINSEL_IDX: rdata_nxt = alert_sel_r;
        gpf_pkg::I2C_PINSEL_IDX: rdata_nxt = i2c_sel;
        gpf_pkg::MULTIFUNC_IDX: rdata_nxt = multi_sel;
        gpf_pkg::POWER_PINSEL_IDX: rdata_nxt = power_sel_r;
        gpf_pkg::TEST_A_IDX: rdata_nxt = test_a_r;
        gpf_pkg::TEST_B_IDX: rdata_nxt = test_b_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Disable bits are active high, so a clear bit opens the window
    rom_hit_nxt = mem_req & (
      (rom_page_hit(mem_addr, gpf_pkg::LOW_ROM_PAGE) & ~rom_port_r[gpf_pkg::LOW_ROM_DIS_BIT])
      | (rom_page_hit(mem_addr, gpf_pkg::HIGH_ROM_PAGE)
         & ~rom_port_r[gpf_pkg::HIGH_ROM_DIS_BIT]));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      rom_hit_r <= 1'b0;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
      rom_hit_r <= rom_hit_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign rom_hit = rom_hit_r;

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  gpf_route u_route (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .rom_port(rom_port_r),
    .alert_sel(alert_sel_r),
    .i2c_sel(i2c_sel),
    .multi_sel(multi_sel),
    .power_sel(power_sel_r),
    .flash_en(flash_en_r),
    .route(route)
  );

endmodule

`default_nettype wire

// ---- hw/gpf_pkg.sv ----
// Package for the global pin-function configuration block: offsets, masks,
// reset values, the select carrier and the shared-pin enumeration.
// Assumes a single sys_clk domain and the indexed configuration port.

package gpf_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] GLOBAL_OPT_IDX = 8'h24;
  localparam logic [7:0] ROM_PORT_IDX = 8'h28;
  localparam logic [7:0] ALERT_PINSEL_IDX = 8'h29;
  localparam logic [7:0] I2C_PINSEL_IDX = 8'h2A;
  localparam logic [7:0] MULTIFUNC_IDX = 8'h2C;
  localparam logic [7:0] POWER_PINSEL_IDX = 8'h2D;
  localparam logic [7:0] TEST_A_IDX = 8'h2E;
  localparam logic [7:0] TEST_B_IDX = 8'h2F;

  // ----------------------------------------------------------------
  // Implemented-bit masks (reserved bits clear)
  // ----------------------------------------------------------------
  localparam logic [7:0] GLOBAL_OPT_MASK = 8'h02;
  localparam logic [7:0] ROM_PORT_MASK = 8'h7F;
  localparam logic [7:0] ALERT_PINSEL_MASK = 8'h4F;
  localparam logic [7:0] I2C_SYS_MASK = 8'h03;
  localparam logic [7:0] I2C_BAT_MASK = 8'h30;
  localparam logic [7:0] MULTI_SYS_MASK = 8'hEB;
  localparam logic [7:0] MULTI_BAT_MASK = 8'h04;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ROM_PORT_RST = 8'h50;
  localparam logic [7:0] ALERT_PINSEL_RST = 8'h04;
  localparam logic [7:0] I2C_PINSEL_RST = 8'h00;
  localparam logic [7:0] MULTIFUNC_RST = 8'h00;
  localparam logic [7:0] POWER_PINSEL_RST = 8'h21;
  localparam logic [7:0] TEST_RST = 8'h00;
  // Edges the strap is followed after reset, long enough to refill its synchroniser
  localparam logic [2:0] STRAP_WAIT_CYCLES = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLASH_EN_BIT = 1;
  localparam int LOW_ROM_DIS_BIT = 4;
  localparam int HIGH_ROM_DIS_BIT = 3;
  localparam int PORT_MODE_TOP_BIT = 2;
  localparam int ALERT_SEL_BIT = 6;
  localparam int UART_A_SEL_BIT = 3;
  localparam int PAIR_SEL_HI_BIT = 2;
  localparam int PAIR_SEL_LO_BIT = 1;
  localparam int GAME_SEL_BIT = 0;
  localparam int EXT_DUMMY_BIT = 5;
  localparam int FAST_READ_BIT = 4;
  localparam int I2C_SEL_BIT = 1;
  localparam int KBD_SEL_BIT = 0;
  localparam int RST3_SEL_BIT = 6;
  localparam int RST2_SEL_BIT = 5;
  localparam int THERM_SD_BIT = 2;

  // Upper address halves of the two ROM windows
  localparam logic [15:0] LOW_ROM_PAGE = 16'h000E;
  localparam logic [15:0] HIGH_ROM_PAGE = 16'hFFFE;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GPF_PAIR_FAN = 2'b00,
    GPF_PAIR_GPIO = 2'b01,
    GPF_PAIR_MIDI = 2'b10
  } gpf_pair_t;

  typedef struct packed {
    logic alert_is_monitor_irq;
    logic uart_a_is_gpio;
    gpf_pair_t pair_func;
    logic game_is_gpio;
    logic i2c_on_pins;
    logic kbd_is_gpio;
    logic pin_three_three_is_reset;
    logic pin_three_two_is_reset;
    logic [7:0] power_pins_are_gpio;
    logic flash_enable;
    logic flash_extend_dummy;
    logic flash_fast_read;
    logic thermal_shutdown_en;
    logic parallel_mode_sel;
  } gpf_route_t;

endpackage

// ---- hw/gpf_route.sv ----
// Turns the stored selects into effective pin routing, one cycle later.
// Assumes register images come from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none

module gpf_route (
  // Clocking
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // Register images
  input wire logic [7:0] rom_port,
  input wire logic [7:0] alert_sel,
  input wire logic [7:0] i2c_sel,
  input wire logic [7:0] multi_sel,
  input wire logic [7:0] power_sel,
  input wire logic flash_en,
  // Routing
  output gpf_pkg::gpf_route_t route
);

  gpf_pkg::gpf_route_t route_r;
  gpf_pkg::gpf_route_t route_nxt;

  always_comb begin
    route_nxt = route_r;
    route_nxt.alert_is_monitor_irq = alert_sel[gpf_pkg::ALERT_SEL_BIT];
    route_nxt.uart_a_is_gpio = alert_sel[gpf_pkg::UART_A_SEL_BIT];
    if (alert_sel[gpf_pkg::PAIR_SEL_HI_BIT]) begin
      route_nxt.pair_func = gpf_pkg::GPF_PAIR_MIDI;
    end else if (alert_sel[gpf_pkg::PAIR_SEL_LO_BIT]) begin
      route_nxt.pair_func = gpf_pkg::GPF_PAIR_GPIO;
    end else begin
      route_nxt.pair_func = gpf_pkg::GPF_PAIR_FAN;
    end
    route_nxt.game_is_gpio = alert_sel[gpf_pkg::GAME_SEL_BIT];
    route_nxt.i2c_on_pins = i2c_sel[gpf_pkg::I2C_SEL_BIT];
    route_nxt.kbd_is_gpio = i2c_sel[gpf_pkg::KBD_SEL_BIT];
    // I2C ownership masks the reset-output selects
    route_nxt.pin_three_three_is_reset = multi_sel[gpf_pkg::RST3_SEL_BIT]
      & ~i2c_sel[gpf_pkg::I2C_SEL_BIT];
    route_nxt.pin_three_two_is_reset = multi_sel[gpf_pkg::RST2_SEL_BIT]
      & ~i2c_sel[gpf_pkg::I2C_SEL_BIT];
    route_nxt.power_pins_are_gpio = power_sel;
    route_nxt.flash_enable = flash_en;
    route_nxt.flash_extend_dummy = i2c_sel[gpf_pkg::EXT_DUMMY_BIT] & flash_en;
    route_nxt.flash_fast_read = i2c_sel[gpf_pkg::FAST_READ_BIT] & flash_en;
    route_nxt.thermal_shutdown_en = multi_sel[gpf_pkg::THERM_SD_BIT];
    route_nxt.parallel_mode_sel = ~rom_port[gpf_pkg::PORT_MODE_TOP_BIT];
  end

  // Registered so a select write shows on the pins the cycle after it lands
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      route_r <= '0;
    end else if (ce) begin
      route_r <= route_nxt;
    end
  end

  assign route = route_r;

endmodule

`default_nettype wire

// ---- hw/gpf_sync3.sv ----
// Three-stage synchroniser for a level arriving from a pin.
// The output moves only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module gpf_sync3 #(
  parameter logic INIT = 1'b1
) (
  // Clocking
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;
  logic out_nxt;

  // First stage feeds the second stage only
  always_comb begin
    out_nxt = out_r;
    if (s2_r == s3_r) begin
      out_nxt = s3_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      out_r <= INIT;
    end else if (ce) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule

`default_nettype wire

// ---- verification/gpf_cfg_checker.sv ----
// Checker for the global pin-function configuration block.
// Sees only the top module's ports; bound in at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module gpf_cfg_checker (
  // Clocking and well reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic resume_well_reset_n,
  // Configuration port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  // Host memory and routing
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic rom_hit,
  input wire gpf_pkg::gpf_route_t route
);
  // ----------------------------------------------------------------
  // Window-disable shadow
  // ----------------------------------------------------------------
  // Only bits 4:3 of the ROM register matter for decode, so only they are tracked
  logic [1:0] win_r;
  logic [1:0] win_nxt;

  always_comb begin
    win_nxt = win_r;
    if (srst) begin
      win_nxt = 2'b10;
    end else if (ce && cfg_wr && cfg_index == 8'h28) begin
      win_nxt = cfg_wdata[4:3];
    end
  end

  always_ff @(posedge sys_clk) begin
    win_r <= win_nxt;
  end

  function automatic logic [1:0] pair_of(input logic [7:0] d);
    return d[2] ? 2'b10 : {1'b0, d[1]};
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_low_window: assert property (ce && mem_req && mem_addr[31:16] == 16'h000E |=>
    rom_hit == !$past(win_r[1])) else $error("low ROM window decode wrong");
  a_high_window: assert property (ce && mem_req && mem_addr[31:16] == 16'hFFFE |=>
    rom_hit == !$past(win_r[0])) else $error("high ROM window decode wrong");
  a_alert_route: assert property (ce && cfg_wr && cfg_index == 8'h29 ##1 ce |=>
    route.alert_is_monitor_irq == $past(cfg_wdata[6], 2)) else $error("alert route wrong");
  a_pair_route: assert property (ce && cfg_wr && cfg_index == 8'h29 ##1 ce |=>
    route.pair_func == pair_of($past(cfg_wdata, 2))) else $error("pin pair route wrong");
  a_reset_outs_gated: assert property (route.i2c_on_pins |->
    !route.pin_three_three_is_reset && !route.pin_three_two_is_reset)
    else $error("reset output selected while I2C owns the pins");
  a_flash_gated: assert property (!route.flash_enable |->
    !route.flash_extend_dummy && !route.flash_fast_read) else $error("flash mode not gated");
  a_reserved_read: assert property (ce && cfg_rd && cfg_index == 8'h29 |=>
    (cfg_rdata & 8'hB0) == 8'h00) else $error("reserved pin-select bits read non-zero");
  a_unmapped_read: assert property (ce && cfg_rd && cfg_index == 8'h27 |=>
    cfg_rdata == 8'h00) else $error("unmapped index read non-zero");
  a_rdata_hold: assert property (!(ce && cfg_rd) |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  a_resume_defaults: assert property ((ce && !resume_well_reset_n) [*8] |->
    route.power_pins_are_gpio == 8'h21 && !route.pin_three_two_is_reset)
    else $error("resume-well reset values not applied");

  c_rom_hit: cover property (ce && mem_req ##1 rom_hit);
  c_pin_write: cover property (ce && cfg_wr && cfg_index == 8'h29);
  c_resume: cover property ((!resume_well_reset_n) [*8]);
endmodule

bind gpf_global_pin_cfg gpf_cfg_checker u_chk (.sys_clk, .srst, .ce, .resume_well_reset_n,
  .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata, .cfg_rdata, .mem_req, .mem_addr, .rom_hit, .route);

`default_nettype wire

// ---- verification/testbench.sv ----
// Testbench for the global pin-function configuration block.
// Drives the configuration port, memory probe and well resets itself.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic resume_well_reset_n = 1'b1;
  logic battery_reset_n = 1'b1;
  logic strap_serial_flash_en = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_index = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic mem_req = 1'b0;
  logic [31:0] mem_addr = 32'h00000000;
  logic rom_hit;
  gpf_pkg::gpf_route_t route;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] d;
  logic [31:0] e;
  logic [31:0] g;
  logic [15:0] rst_tab [8] = '{16'h2402, 16'h2850, 16'h2904, 16'h2A00, 16'h2C00, 16'h2D21,
                               16'h2E00, 16'h2F00};
  // Index, written value, value read back
  logic [23:0] wr_tab [12] = '{24'h24FF02, 24'h28FF78, 24'h29FF4F, 24'h2AFF33, 24'h2CFFEF,
    24'h2DFFFF, 24'h2EFFFF, 24'h2FA5A5, 24'h27FF00, 24'h280303, 24'h280703, 24'h28FC7B};
  logic [7:0] sel_tab [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h49, 8'hFF};
  logic [15:0] fl_tab [4] = '{16'h0230, 16'h0030, 16'h0210, 16'h0220};
  logic [7:0] win_tab [4] = '{8'h00, 8'h08, 8'h10, 8'h18};

  always #20 sys_clk = ~sys_clk;

  gpf_global_pin_cfg uut (.sys_clk, .srst, .ce, .resume_well_reset_n, .battery_reset_n,
    .strap_serial_flash_en, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata, .cfg_rdata, .mem_req,
    .mem_addr, .rom_hit, .route);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_index <= idx;
    cfg_wdata <= dat;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_index <= idx;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    @(negedge sys_clk);
    check($sformatf("register %h", idx), {24'h0, exp}, {24'h0, cfg_rdata});
  endtask

  task automatic probe(input logic [31:0] a, input logic exp);
    @(posedge sys_clk);
    mem_req <= 1'b1;
    mem_addr <= a;
    @(posedge sys_clk);
    mem_req <= 1'b0;
    @(negedge sys_clk);
    check($sformatf("rom_hit at %h", a), {31'h0, exp}, {31'h0, rom_hit});
  endtask

  // Register update then route flop: route lands on the edge after the write edge
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  // Well resets pass a three-stage synchroniser, so hold them well past it
  task automatic wells(input logic rsm, input logic bat);
    @(posedge sys_clk);
    resume_well_reset_n <= rsm;
    battery_reset_n <= bat;
    repeat (10) @(posedge sys_clk);
    resume_well_reset_n <= 1'b1;
    battery_reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    wells(1'b0, 1'b0);
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    end
    foreach (wr_tab[i]) begin
      wr(wr_tab[i][23:16], wr_tab[i][15:8]);
      rd(wr_tab[i][23:16], wr_tab[i][7:0]);
    end
    foreach (sel_tab[i]) begin
      d = sel_tab[i];
      wr(8'h29, d);
      settle();
      e = {27'h0, d[6], d[3], (d[2] ? 2'b10 : {1'b0, d[1]}), d[0]};
      g = {27'h0, route.alert_is_monitor_irq, route.uart_a_is_gpio, route.pair_func,
           route.game_is_gpio};
      check("alert uart pair game route", e, g);
    end
    wr(8'h2C, 8'h60);
    for (int j = 0; j < 4; j++) begin
      d = j[7:0];
      wr(8'h2A, d);
      settle();
      e = {28'h0, d[1], d[0], ~d[1], ~d[1]};
      g = {28'h0, route.i2c_on_pins, route.kbd_is_gpio, route.pin_three_three_is_reset,
           route.pin_three_two_is_reset};
      check("i2c keyboard reset-out route", e, g);
    end
    foreach (fl_tab[i]) begin
      wr(8'h24, fl_tab[i][15:8]);
      wr(8'h2A, fl_tab[i][7:0]);
      settle();
      e = {29'h0, fl_tab[i][9], fl_tab[i][9] & fl_tab[i][5], fl_tab[i][9] & fl_tab[i][4]};
      g = {29'h0, route.flash_enable, route.flash_extend_dummy, route.flash_fast_read};
      check("flash mode route", e, g);
    end
    for (int j = 0; j < 2; j++) begin
      d = 8'hA5 ^ {8{j[0]}};
      wr(8'h2D, d);
      wr(8'h2C, {5'h0, d[0], 2'b00});
      settle();
      e = {23'h0, d, d[0]};
      g = {23'h0, route.power_pins_are_gpio, route.thermal_shutdown_en};
      check("power pins and thermal shutdown", e, g);
    end
    foreach (win_tab[i]) begin
      wr(8'h28, win_tab[i]);
      probe(32'h000E1234, ~win_tab[i][4]);
      probe(32'hFFFE0000, ~win_tab[i][3]);
      probe(32'h000F0000, 1'b0);
      check("parallel mode", 32'h1, {31'h0, route.parallel_mode_sel});
    end
    // A write while the clock enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(8'h2E, 8'h11);
    ce <= 1'b1;
    rd(8'h2E, 8'hFF);
    wr(8'h2A, 8'h33);
    wr(8'h2C, 8'h64);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h2D, 8'h5A);
    rd(8'h29, 8'h04);
    rd(8'h2C, 8'h64);
    wells(1'b0, 1'b1);
    rd(8'h2D, 8'h21);
    rd(8'h2C, 8'h04);
    rd(8'h2A, 8'h30);
    wells(1'b1, 1'b0);
    rd(8'h2C, 8'h00);
    rd(8'h2A, 8'h00);
    results();
  end
endmodule

`default_nettype wire
